// file: mmnp_map.vh
// address map, lock, fuse and signature constants for the memory map and protection block
`ifndef MMNP_MAP_VH
`define MMNP_MAP_VH
// flash word map, larger variant
`define MMNP_FL_TABLE_START 17'h0F000
`define MMNP_FL_APP_END     17'h0FFFF
`define MMNP_FL_BOOT_START  17'h10000
`define MMNP_FL_BOOT_END    17'h10FFF
// flash word map, smaller variant
`define MMNP_FS_TABLE_START 17'h07800
`define MMNP_FS_APP_END     17'h07FFF
`define MMNP_FS_BOOT_START  17'h08000
`define MMNP_FS_BOOT_END    17'h087FF
// data byte map
`define MMNP_IO_END         24'h000FFF
`define MMNP_EE_START       24'h001000
`define MMNP_EE_END         24'h0017FF
`define MMNP_SRAM_START     24'h002000
`define MMNP_SRAM_END_L     24'h003FFF
`define MMNP_SRAM_END_S     24'h002FFF
`define MMNP_EXT_END        24'hFFFFFF
// data region codes
`define MMNP_RG_IO          3'h0
`define MMNP_RG_EE          3'h1
`define MMNP_RG_RSV         3'h2
`define MMNP_RG_SRAM        3'h3
`define MMNP_RG_EXT         3'h4
`define MMNP_RG_NONE        3'h7
// lock byte fields, one means unprogrammed
`define MMNP_LOCK_RESET     8'hFF
`define MMNP_FUSE_RESET     8'hFF
// nvm target codes
`define MMNP_TG_FLASH       2'h0
`define MMNP_TG_USIG        2'h1
`define MMNP_TG_PSIG        2'h2
`define MMNP_TG_FUSE        2'h3
// signature row layout (byte offsets)
`define MMNP_SIG_ID0        4'h0
`define MMNP_SIG_ID1        4'h1
`define MMNP_SIG_ID2        4'h2
`define MMNP_SIG_LOT0       4'h3
`define MMNP_SIG_LOT1       4'h4
`define MMNP_SIG_WAFER      4'h5
`define MMNP_SIG_XY0        4'h6
`define MMNP_SIG_XY1        4'h7
`define MMNP_SIG_CAL0       4'h8
`define MMNP_SIG_CAL1       4'h9
`define MMNP_SIG_CAL2       4'hA
`define MMNP_SIG_LEN        16
`define MMNP_CAL_AUTO_N     2
`endif

// file: mmnp_data_decode.v
// data-space byte address decoder
`timescale 1ns/1ps
`default_nettype none
`include "mmnp_map.vh"
module mmnp_data_decode #(
  parameter BIG = 1
) (
  input  wire [23:0] i_addr,
  input  wire        i_ee_mapped,
  output reg  [2:0]  o_region
);
  wire [23:0] sram_end = (BIG != 0) ? `MMNP_SRAM_END_L : `MMNP_SRAM_END_S; // variant sram top

  // fixed starts, linear decode without bank bits
  always @*
  begin
    if (i_addr <= `MMNP_IO_END)
      o_region = `MMNP_RG_IO;
    else if (i_addr <= `MMNP_EE_END)
      o_region = i_ee_mapped ? `MMNP_RG_EE : `MMNP_RG_RSV;
    else if (i_addr < `MMNP_SRAM_START)
      o_region = `MMNP_RG_RSV;
    else if (i_addr <= sram_end)
      o_region = `MMNP_RG_SRAM;
    else
      o_region = `MMNP_RG_EXT;
  end
endmodule
`default_nettype wire

// file: mmnp_flash_decode.v
// flash word address section decoder
`timescale 1ns/1ps
`default_nettype none
`include "mmnp_map.vh"
module mmnp_flash_decode #(
  parameter BIG = 1
) (
  input  wire [16:0] i_waddr,
  output wire        o_valid,
  output wire        o_boot,
  output wire        o_table
);
  wire [16:0] tstart = (BIG != 0) ? `MMNP_FL_TABLE_START : `MMNP_FS_TABLE_START;
  wire [16:0] bstart = (BIG != 0) ? `MMNP_FL_BOOT_START : `MMNP_FS_BOOT_START;
  wire [16:0] bend   = (BIG != 0) ? `MMNP_FL_BOOT_END : `MMNP_FS_BOOT_END;
  // boot directly above application, table is top of application
  assign o_valid = (i_waddr <= bend);
  assign o_boot  = (i_waddr >= bstart) && o_valid;
  assign o_table = (i_waddr >= tstart) && (i_waddr < bstart);
endmodule
`default_nettype wire

// file: mmnp_core.v
// memory map and nvm protection core
`timescale 1ns/1ps
`default_nettype none
`include "mmnp_map.vh"
module mmnp_core #(
  parameter BIG   = 1,                  // 1 larger variant, 0 smaller
  parameter PAGE  = 256,                // user row size in words
  parameter [7:0] ID0 = 8'hA5,          // device id bytes, arbitrary values
  parameter [7:0] ID1 = 8'h5A,          // arbitrary
  parameter [7:0] ID2 = 8'h3C,          // arbitrary
  parameter [47:0] SERIAL = 48'h0,      // lot, wafer, x/y coordinates
  parameter [23:0] CAL = 24'h0          // three calibration bytes
) (
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // cpu flash command, same clock
  input  wire        i_cpu_req,         // one-cycle nvm request
  input  wire        i_cpu_wr,          // 1 write/erase, 0 read
  input  wire        i_cpu_erase,       // erase instead of write
  input  wire [1:0]  i_cpu_tgt,         // target space
  input  wire [16:0] i_cpu_waddr,       // word address
  input  wire [15:0] i_cpu_wdata,
  input  wire [16:0] i_cpu_pc,          // word address of store instruction
  // lock write from cpu
  input  wire        i_cpu_lock_wr,
  input  wire [7:0]  i_cpu_lock_data,
  // programming debug port, pins, synchronised here
  input  wire        i_pdp_req,         // level toggle-free request pulse pin
  input  wire        i_pdp_wr,
  input  wire        i_pdp_erase,
  input  wire        i_pdp_chip_erase,
  input  wire        i_pdp_lock_wr,
  input  wire [1:0]  i_pdp_tgt,
  input  wire [16:0] i_pdp_waddr,
  input  wire [15:0] i_pdp_wdata,
  // fetch check
  input  wire [16:0] i_fetch_waddr,
  input  wire        i_fetch_data_space, // fetch aimed at data space
  // data space
  input  wire [23:0] i_daddr,
  input  wire        i_dwr,
  input  wire        i_ee_mapped,
  input  wire [7:0]  i_rsv_rdata_in,    // unused data of reserved range
  // outputs
  output reg         o_nvm_go,          // accepted flash/user row program
  output reg         o_nvm_erase,
  output reg  [1:0]  o_nvm_tgt,
  output reg  [16:0] o_nvm_waddr,
  output reg  [15:0] o_nvm_wdata,       // one 16-bit word per location
  output reg         o_nvm_rd,          // accepted read
  output reg         o_reject,          // request refused
  output reg  [15:0] o_sig_rdata,       // signature/fuse read data
  output reg  [7:0]  o_lock,
  output reg  [7:0]  o_fuse,
  output reg         o_chip_erase_busy,
  output reg         o_cal_load,        // pulses per auto calibration byte
  output reg  [1:0]  o_cal_sel,
  output reg  [7:0]  o_cal_data,
  output reg         o_fetch_fault,
  output reg  [2:0]  o_dregion,
  output reg         o_dwr_en,
  output reg  [7:0]  o_rsv_rdata
);
  // chip erase states
  localparam CE_IDLE  = 2'h0;
  localparam CE_FLASH = 2'h1;
  localparam CE_LOCK  = 2'h2;

  // synchronisers for pins
  reg  [24:0] pdp_s1;                   // first stage
  reg  [24:0] pdp_s2;                   // second stage
  reg  [16:0] pdp_a1;
  reg  [16:0] pdp_a2;
  reg  [15:0] pdp_d1;
  reg  [15:0] pdp_d2;
  reg         pdp_req_d;                // edge history
  reg  [1:0]  ce_state;
  reg  [16:0] ce_addr;
  reg  [1:0]  cal_cnt;
  reg         cal_busy;
  reg  [7:0]  next_lock;

  wire [16:0] pc_w;
  wire        pc_boot;
  wire        cmd_valid;
  wire        fetch_valid;
  wire [2:0]  dreg;

  // synchronised programmer signals
  wire        p_req       = pdp_s2[0];
  wire        p_wr        = pdp_s2[1];
  wire        p_erase     = pdp_s2[2];
  wire        p_chip      = pdp_s2[3];
  wire        p_lock      = pdp_s2[4];
  wire [1:0]  p_tgt       = pdp_s2[6:5];
  wire [7:0]  p_lockd     = pdp_s2[14:7];
  wire        p_req_rise  = p_req & ~pdp_req_d;

  // section decode of issuing store instruction
  mmnp_flash_decode #(.BIG(BIG)) u_pc_dec (
    .i_waddr (i_cpu_pc),
    .o_valid (),
    .o_boot  (pc_boot),
    .o_table ()
  );

  // range check of target address
  mmnp_flash_decode #(.BIG(BIG)) u_cmd_dec (
    .i_waddr (i_cpu_waddr),
    .o_valid (cmd_valid),
    .o_boot  (),
    .o_table ()
  );

  // data space decoder
  mmnp_data_decode #(.BIG(BIG)) u_ddec (
    .i_addr      (i_daddr),
    .i_ee_mapped (i_ee_mapped),
    .o_region    (dreg)
  );

  assign pc_w = i_fetch_waddr;

  // fetch range valid in program memory
  mmnp_flash_decode #(.BIG(BIG)) u_fetch_dec (
    .i_waddr (pc_w),
    .o_valid (fetch_valid),
    .o_boot  (),
    .o_table ()
  );

  // lock merge: bits may only go from one to zero
  function [7:0] tighten;
    input [7:0] cur;
    input [7:0] req;
    begin
      tighten = cur & req;
    end
  endfunction

  // signature byte lookup
  function [7:0] sig_byte;
    input [3:0] idx;
    begin
      case (idx)
        `MMNP_SIG_ID0:   sig_byte = ID0;
        `MMNP_SIG_ID1:   sig_byte = ID1;
        `MMNP_SIG_ID2:   sig_byte = ID2;
        `MMNP_SIG_LOT0:  sig_byte = SERIAL[7:0];
        `MMNP_SIG_LOT1:  sig_byte = SERIAL[15:8];
        `MMNP_SIG_WAFER: sig_byte = SERIAL[23:16];
        `MMNP_SIG_XY0:   sig_byte = SERIAL[31:24];
        `MMNP_SIG_XY1:   sig_byte = SERIAL[39:32];
        `MMNP_SIG_CAL0:  sig_byte = CAL[7:0];
        `MMNP_SIG_CAL1:  sig_byte = CAL[15:8];
        `MMNP_SIG_CAL2:  sig_byte = CAL[23:16];
        default:         sig_byte = 8'h00;
      endcase
    end
  endfunction

  // pin synchronisers, two flops deep
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pdp_s1    <= 25'h0000000;
      pdp_s2    <= 25'h0000000;
      pdp_a1    <= 17'h00000;
      pdp_a2    <= 17'h00000;
      pdp_d1    <= 16'h0000;
      pdp_d2    <= 16'h0000;
      pdp_req_d <= 1'b0;
    end
    else
    begin
      pdp_s1    <= {10'h000, i_pdp_wdata[7:0], i_pdp_tgt, i_pdp_lock_wr,
                    i_pdp_chip_erase, i_pdp_erase, i_pdp_wr, i_pdp_req};
      pdp_s2    <= pdp_s1;
      pdp_a1    <= i_pdp_waddr;
      pdp_a2    <= pdp_a1;
      pdp_d1    <= i_pdp_wdata;
      pdp_d2    <= pdp_d1;
      pdp_req_d <= p_req;
    end
  end

  // next lock value from either writer
  always @*
  begin
    next_lock = o_lock;
    if (i_cpu_lock_wr)
      next_lock = tighten(next_lock, i_cpu_lock_data);
    if (p_req_rise && p_lock)
      next_lock = tighten(next_lock, p_lockd);
  end

  // command acceptance, locks, fuses, chip erase
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_nvm_go          <= 1'b0;
      o_nvm_erase       <= 1'b0;
      o_nvm_tgt         <= `MMNP_TG_FLASH;
      o_nvm_waddr       <= 17'h00000;
      o_nvm_wdata       <= 16'h0000;
      o_nvm_rd          <= 1'b0;
      o_reject          <= 1'b0;
      o_sig_rdata       <= 16'h0000;
      o_lock            <= `MMNP_LOCK_RESET;
      o_fuse            <= `MMNP_FUSE_RESET;
      o_chip_erase_busy <= 1'b0;
      ce_state          <= CE_IDLE;
      ce_addr           <= 17'h00000;
    end
    else
    begin
      o_nvm_go <= 1'b0;
      o_nvm_rd <= 1'b0;
      o_reject <= 1'b0;
      case (ce_state)
        CE_IDLE:
        begin
          o_lock <= next_lock;
          if (p_req_rise && p_chip)
          begin
            ce_state          <= CE_FLASH;
            ce_addr           <= 17'h00000;
            o_chip_erase_busy <= 1'b1;
          end
          else if (p_req_rise && !p_lock)
          begin
            // programmer side
            o_nvm_tgt   <= p_tgt;
            o_nvm_waddr <= pdp_a2;
            o_nvm_wdata <= pdp_d2;
            o_nvm_erase <= p_erase;
            if (p_tgt == `MMNP_TG_PSIG)
            begin
              o_reject    <= p_wr;
              o_nvm_rd    <= ~p_wr;
              o_sig_rdata <= {8'h00, sig_byte(pdp_a2[3:0])};
            end
            else if (p_tgt == `MMNP_TG_FUSE)
            begin
              if (p_wr)
                o_fuse <= pdp_d2[7:0];
              o_nvm_rd    <= ~p_wr;
              o_sig_rdata <= {8'h00, o_fuse};
            end
            else if (p_tgt == `MMNP_TG_USIG && pdp_a2 >= PAGE)
              o_reject <= 1'b1;
            else
            begin
              o_nvm_go <= p_wr;
              o_nvm_rd <= ~p_wr;
            end
          end
          else if (i_cpu_req)
          begin
            // software side
            o_nvm_tgt   <= i_cpu_tgt;
            o_nvm_waddr <= i_cpu_waddr;
            o_nvm_wdata <= i_cpu_wdata;
            o_nvm_erase <= i_cpu_erase;
            if (i_cpu_tgt == `MMNP_TG_PSIG)
            begin
              o_reject    <= i_cpu_wr;
              o_nvm_rd    <= ~i_cpu_wr;
              o_sig_rdata <= {8'h00, sig_byte(i_cpu_waddr[3:0])};
            end
            else if (i_cpu_tgt == `MMNP_TG_FUSE)
            begin
              o_reject    <= i_cpu_wr;
              o_nvm_rd    <= ~i_cpu_wr;
              o_sig_rdata <= {8'h00, o_fuse};
            end
            else if (i_cpu_wr && !pc_boot)
              o_reject <= 1'b1;
            else if (i_cpu_tgt == `MMNP_TG_USIG && i_cpu_waddr >= PAGE)
              o_reject <= 1'b1;
            else if (i_cpu_tgt == `MMNP_TG_FLASH && !cmd_valid)
              o_reject <= 1'b1;
            else
            begin
              o_nvm_go <= i_cpu_wr;
              o_nvm_rd <= ~i_cpu_wr;
            end
          end
        end
        CE_FLASH:
        begin
          // erase flash words only, user row untouched
          o_nvm_go    <= 1'b1;
          o_nvm_erase <= 1'b1;
          o_nvm_tgt   <= `MMNP_TG_FLASH;
          o_nvm_waddr <= ce_addr;
          o_nvm_wdata <= 16'hFFFF;
          ce_addr     <= ce_addr + 17'h00001;
          if (ce_addr == ((BIG != 0) ? `MMNP_FL_BOOT_END : `MMNP_FS_BOOT_END))
            ce_state <= CE_LOCK;
        end
        CE_LOCK:
        begin
          o_lock            <= `MMNP_LOCK_RESET;
          o_chip_erase_busy <= 1'b0;
          ce_state          <= CE_IDLE;
        end
        default:
          ce_state <= CE_IDLE;
      endcase
    end
  end

  // calibration copy after reset release
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      cal_cnt    <= 2'h0;
      cal_busy   <= 1'b1;
      o_cal_load <= 1'b0;
      o_cal_sel  <= 2'h0;
      o_cal_data <= 8'h00;
    end
    else
    begin
      o_cal_load <= 1'b0;
      if (cal_busy)
      begin
        o_cal_load <= 1'b1;
        o_cal_sel  <= cal_cnt;
        o_cal_data <= sig_byte(`MMNP_SIG_CAL0 + {2'h0, cal_cnt});
        cal_cnt    <= cal_cnt + 2'h1;
        if (cal_cnt == (`MMNP_CAL_AUTO_N - 1))
          cal_busy <= 1'b0;
      end
    end
  end

  // fetch check and data space routing
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_fetch_fault <= 1'b0;
      o_dregion     <= `MMNP_RG_NONE;
      o_dwr_en      <= 1'b0;
      o_rsv_rdata   <= 8'h00;
    end
    else
    begin
      o_fetch_fault <= i_fetch_data_space | ~fetch_valid;
      o_dregion     <= dreg;
      o_dwr_en      <= i_dwr && (dreg != `MMNP_RG_RSV);
      o_rsv_rdata   <= (dreg == `MMNP_RG_RSV) ? 8'h00 : i_rsv_rdata_in;
    end
  end
endmodule
`default_nettype wire

// file: mmnp_checker.sv
// concurrent checks on the ports of the memory map and protection core
`timescale 1ns/1ps
`default_nettype none
`include "mmnp_map.vh"
module mmnp_checker #(
  parameter [23:0] CAL = 24'h0  // calibration bytes given to the core
) (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_cpu_req,
  input wire logic        i_cpu_wr,
  input wire logic        i_cpu_erase,
  input wire logic [1:0]  i_cpu_tgt,
  input wire logic [16:0] i_cpu_waddr,
  input wire logic [15:0] i_cpu_wdata,
  input wire logic [16:0] i_cpu_pc,
  input wire logic        i_fetch_data_space,
  input wire logic [23:0] i_daddr,
  input wire logic        o_nvm_go,
  input wire logic        o_nvm_erase,
  input wire logic [1:0]  o_nvm_tgt,
  input wire logic [16:0] o_nvm_waddr,
  input wire logic [15:0] o_nvm_wdata,
  input wire logic        o_reject,
  input wire logic [7:0]  o_lock,
  input wire logic        o_chip_erase_busy,
  input wire logic        o_cal_load,
  input wire logic [1:0]  o_cal_sel,
  input wire logic [7:0]  o_cal_data,
  input wire logic        o_fetch_fault,
  input wire logic [2:0]  o_dregion,
  input wire logic        o_dwr_en,
  input wire logic [7:0]  o_rsv_rdata
);
  // a cpu write or erase request that the core must look at
  wire logic cwr = i_cpu_req && i_cpu_wr && !o_chip_erase_busy;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // two calibration bytes land right after reset, then the strobe stops
  sequence s_cal;
    o_cal_load && o_cal_sel == 2'h0 && o_cal_data == CAL[7:0] ##1
    o_cal_load && o_cal_sel == 2'h1 && o_cal_data == CAL[15:8] ##1 !o_cal_load;
  endsequence
  a_cal_reset_load:
    assert property ($fell(i_rst) |=> s_cal) else $error("calibration load wrong");
  a_store_boot_go:
    assert property (cwr && !i_cpu_erase && i_cpu_tgt == `MMNP_TG_FLASH
      && i_cpu_pc >= `MMNP_FL_BOOT_START && i_cpu_pc <= `MMNP_FL_BOOT_END
      && i_cpu_waddr <= `MMNP_FL_BOOT_END |=> o_nvm_go && !o_reject
      && o_nvm_waddr == $past(i_cpu_waddr) && o_nvm_wdata == $past(i_cpu_wdata))
    else $error("boot store not carried out");
  a_store_app_refused:
    assert property (cwr && i_cpu_tgt == `MMNP_TG_FLASH && i_cpu_pc < `MMNP_FL_BOOT_START
      |=> o_reject && !o_nvm_go) else $error("store from application section acted");
  a_sig_fuse_refused:
    assert property (cwr && i_cpu_tgt[1] |=> o_reject && !o_nvm_go)
    else $error("cpu write to fuse or factory row acted");
  a_lock_only_tighten:
    assert property (!$past(i_rst) && !o_chip_erase_busy && !$past(o_chip_erase_busy)
      && !$past(o_chip_erase_busy, 2) |-> (o_lock & ~$past(o_lock)) == 8'h00)
    else $error("lock bit loosened outside chip erase");
  a_region_external:
    assert property (!$past(i_rst) && $past(i_daddr) > `MMNP_SRAM_END_L
      |-> o_dregion == `MMNP_RG_EXT) else $error("address past sram not external");
  a_reserved_quiet:
    assert property (o_dregion == `MMNP_RG_RSV |-> o_rsv_rdata == 8'h00 && !o_dwr_en)
    else $error("reserved range not quiet");
  a_fetch_data_fault:
    assert property (i_fetch_data_space |=> o_fetch_fault) else $error("data fetch passed");
  a_erase_flash_only:
    assert property (o_chip_erase_busy && o_nvm_go |-> o_nvm_erase
      && o_nvm_tgt == `MMNP_TG_FLASH) else $error("chip erase touched other space");
endmodule
bind mmnp_core mmnp_checker #(.CAL(CAL)) mmnp_checker_i (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cpu_req(i_cpu_req), .i_cpu_wr(i_cpu_wr),
  .i_cpu_erase(i_cpu_erase), .i_cpu_tgt(i_cpu_tgt), .i_cpu_waddr(i_cpu_waddr),
  .i_cpu_wdata(i_cpu_wdata), .i_cpu_pc(i_cpu_pc), .i_fetch_data_space(i_fetch_data_space),
  .i_daddr(i_daddr), .o_nvm_go(o_nvm_go), .o_nvm_erase(o_nvm_erase), .o_nvm_tgt(o_nvm_tgt),
  .o_nvm_waddr(o_nvm_waddr), .o_nvm_wdata(o_nvm_wdata), .o_reject(o_reject),
  .o_lock(o_lock), .o_chip_erase_busy(o_chip_erase_busy), .o_cal_load(o_cal_load),
  .o_cal_sel(o_cal_sel), .o_cal_data(o_cal_data), .o_fetch_fault(o_fetch_fault),
  .o_dregion(o_dregion), .o_dwr_en(o_dwr_en), .o_rsv_rdata(o_rsv_rdata));
`default_nettype wire

// file: mmnp_prog_model.sv
// stand-in for the external programmer on the programming port pins
`timescale 1ns/1ps
`default_nettype none
module mmnp_prog_model (
  input  wire logic        i_clk_sys,
  output var  logic        o_pdp_req,
  output var  logic        o_pdp_wr,
  output var  logic        o_pdp_erase,
  output var  logic        o_pdp_chip_erase,
  output var  logic        o_pdp_lock_wr,
  output var  logic [1:0]  o_pdp_tgt,
  output var  logic [16:0] o_pdp_waddr,
  output var  logic [15:0] o_pdp_wdata
);
  // pins idle until the first transfer
  initial
    {o_pdp_req, o_pdp_wr, o_pdp_erase, o_pdp_chip_erase, o_pdp_lock_wr,
     o_pdp_tgt, o_pdp_waddr, o_pdp_wdata} = '0;
  // one transfer: fields settle, request rises, all held, then released
  task automatic send(input logic [3:0] f, input logic [1:0] tg, input logic [16:0] a,
                      input logic [15:0] d);
    @(negedge i_clk_sys);
    {o_pdp_wr, o_pdp_erase, o_pdp_chip_erase, o_pdp_lock_wr} = f;
    o_pdp_tgt = tg;
    o_pdp_waddr = a;
    o_pdp_wdata = d;
    repeat (4) @(negedge i_clk_sys);
    o_pdp_req = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    o_pdp_req = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    // released lines stop showing the last value
    {o_pdp_wr, o_pdp_erase, o_pdp_chip_erase, o_pdp_lock_wr} = 4'h0;
    o_pdp_waddr = ~a;
    o_pdp_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// file: mmnp_core_tb.sv
// self-checking bench for the memory map and protection core
`timescale 1ns/1ps
`default_nettype none
module mmnp_core_tb;
  localparam [23:0] CAL = 24'h00B2A1; // calibration bytes, arbitrary
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_cpu_req = 1'b0, i_cpu_wr = 1'b0, i_cpu_erase = 1'b0;
  logic [1:0] i_cpu_tgt = '0;
  logic [16:0] i_cpu_waddr = '0, i_cpu_pc = '0, i_fetch_waddr = '0, i_pdp_waddr;
  logic [15:0] i_cpu_wdata = '0, i_pdp_wdata;
  logic i_cpu_lock_wr = 1'b0, i_fetch_data_space = 1'b0, i_dwr = 1'b1, i_ee_mapped = 1'b0;
  logic [7:0] i_cpu_lock_data = 8'hFF, i_rsv_rdata_in = '0;
  logic [23:0] i_daddr = '0;
  logic i_pdp_req, i_pdp_wr, i_pdp_erase, i_pdp_chip_erase, i_pdp_lock_wr;
  logic [1:0] i_pdp_tgt, o_nvm_tgt, o_cal_sel;
  logic o_nvm_go, o_nvm_erase, o_nvm_rd, o_reject, o_chip_erase_busy, o_cal_load;
  logic o_fetch_fault, o_dwr_en;
  logic [16:0] o_nvm_waddr, ce_last;
  logic [15:0] o_nvm_wdata, o_sig_rdata;
  logic [7:0] o_lock, o_fuse, o_cal_data, o_rsv_rdata, lk, v;
  logic [2:0] o_dregion;
  logic [1:0] tg;
  logic [16:0] a, pc;
  logic [31:0] seed = 32'd35; // xorshift state
  int num_errors = 0, n_tests = 0, ce_n = 0, w;
  logic [23:0] corner [10] = '{24'h0, 24'hFFF, 24'h1000, 24'h17FF, 24'h1800, 24'h1FFF,
                               24'h2000, 24'h3FFF, 24'h4000, 24'hFFFFFF};
  // id byte 2 arbitrary
  mmnp_core #(.CAL(CAL), .ID2(8'h7E)) mmnp_core_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cpu_req(i_cpu_req), .i_cpu_wr(i_cpu_wr),
    .i_cpu_erase(i_cpu_erase), .i_cpu_tgt(i_cpu_tgt), .i_cpu_waddr(i_cpu_waddr),
    .i_cpu_wdata(i_cpu_wdata), .i_cpu_pc(i_cpu_pc), .i_cpu_lock_wr(i_cpu_lock_wr),
    .i_cpu_lock_data(i_cpu_lock_data), .i_pdp_req(i_pdp_req), .i_pdp_wr(i_pdp_wr),
    .i_pdp_erase(i_pdp_erase), .i_pdp_chip_erase(i_pdp_chip_erase),
    .i_pdp_lock_wr(i_pdp_lock_wr), .i_pdp_tgt(i_pdp_tgt), .i_pdp_waddr(i_pdp_waddr),
    .i_pdp_wdata(i_pdp_wdata), .i_fetch_waddr(i_fetch_waddr),
    .i_fetch_data_space(i_fetch_data_space), .i_daddr(i_daddr), .i_dwr(i_dwr),
    .i_ee_mapped(i_ee_mapped), .i_rsv_rdata_in(i_rsv_rdata_in), .o_nvm_go(o_nvm_go),
    .o_nvm_erase(o_nvm_erase), .o_nvm_tgt(o_nvm_tgt), .o_nvm_waddr(o_nvm_waddr),
    .o_nvm_wdata(o_nvm_wdata), .o_nvm_rd(o_nvm_rd), .o_reject(o_reject),
    .o_sig_rdata(o_sig_rdata), .o_lock(o_lock), .o_fuse(o_fuse),
    .o_chip_erase_busy(o_chip_erase_busy), .o_cal_load(o_cal_load), .o_cal_sel(o_cal_sel),
    .o_cal_data(o_cal_data), .o_fetch_fault(o_fetch_fault), .o_dregion(o_dregion),
    .o_dwr_en(o_dwr_en), .o_rsv_rdata(o_rsv_rdata));
  mmnp_prog_model mmnp_prog_model_i (.i_clk_sys(i_clk_sys), .o_pdp_req(i_pdp_req),
    .o_pdp_wr(i_pdp_wr), .o_pdp_erase(i_pdp_erase), .o_pdp_chip_erase(i_pdp_chip_erase),
    .o_pdp_lock_wr(i_pdp_lock_wr), .o_pdp_tgt(i_pdp_tgt), .o_pdp_waddr(i_pdp_waddr),
    .o_pdp_wdata(i_pdp_wdata));
  always #25 i_clk_sys = ~i_clk_sys;
  // count erase strobes of a chip erase and keep the last address
  always @(posedge i_clk_sys)
    if (o_chip_erase_busy && o_nvm_go)
    begin
      ce_n <= ce_n + 1;
      ce_last <= o_nvm_waddr;
    end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected answer: go, read or refuse, one-hot
  function automatic logic [2:0] exp_cpu(input logic wr, input logic [1:0] t,
                                          input logic [16:0] ad, input logic [16:0] p);
    if ((t == 2'h1 && ad >= 17'h00100) || (t == 2'h0 && ad > 17'h10FFF))
      return 3'b001;
    if (!wr)
      return 3'b010;
    if (t[1] || (t == 2'h0 && p < 17'h10000))
      return 3'b001;
    return 3'b100;
  endfunction
  // expected data region of a byte address
  function automatic logic [2:0] rg(input logic [23:0] ad, input logic m);
    if (ad <= 24'h000FFF)
      return 3'h0;
    if (ad <= 24'h0017FF)
      return m ? 3'h1 : 3'h2;
    if (ad < 24'h002000)
      return 3'h2;
    return (ad <= 24'h003FFF) ? 3'h3 : 3'h4;
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one cpu request, answer checked the cycle after
  task automatic cpu(input logic wr, input logic er, input logic [1:0] t,
                     input logic [16:0] ad, input logic [16:0] p);
    logic [2:0] e;
    logic [15:0] dm;
    e = exp_cpu(wr, t, ad, p);
    dm = er ? 16'h0000 : 16'hFFFF;
    {i_cpu_wr, i_cpu_erase, i_cpu_tgt, i_cpu_waddr, i_cpu_pc} = {wr, er, t, ad, p};
    i_cpu_wdata = 16'(rnd());
    i_cpu_req = 1'b1;
    @(negedge i_clk_sys);
    i_cpu_req = 1'b0;
    chk({o_nvm_go, o_nvm_rd, o_reject}, e);
    if (e == 3'b100)
    begin
      chk({o_nvm_erase, o_nvm_tgt, o_nvm_waddr}, {er, t, ad});
      chk(o_nvm_wdata & dm, i_cpu_wdata & dm);
    end
    // let an edge pass so the next request never rises in this time step
    @(negedge i_clk_sys);
  endtask
  // one data address, region and reserved behaviour checked a cycle later
  task automatic dec(input logic [23:0] ad, input logic m);
    logic [2:0] e;
    e = rg(ad, m);
    {i_daddr, i_ee_mapped, i_dwr, i_rsv_rdata_in} = {ad, m, 1'(rnd()), 8'(rnd())};
    @(negedge i_clk_sys);
    chk(o_dregion, e);
    chk({o_dwr_en, o_rsv_rdata}, (e == 3'h2) ? 9'h0 : {i_dwr, i_rsv_rdata_in});
  endtask
  initial
  begin
    repeat (8) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk({o_lock, o_fuse}, 16'hFFFF);
    cpu(1, 0, 0, 17'h00123, 17'h0FFFF);
    cpu(1, 0, 0, 17'h10FFF, 17'h10000);
    cpu(1, 0, 0, 17'h11000, 17'h10FFF);
    cpu(1, 0, 1, 17'h000FF, 17'h10000);
    cpu(1, 0, 1, 17'h00100, 17'h10000);
    cpu(1, 1, 2, 17'h0, 17'h10000);
    cpu(1, 0, 3, 17'h0, 17'h10000);
    cpu(0, 0, 2, 17'h00009, 17'h0);
    chk(o_sig_rdata, {8'h00, CAL[15:8]});
    cpu(0, 0, 2, 17'h00002, 17'h0);
    chk(o_sig_rdata, 16'h007E);
    cpu(0, 0, 3, 17'h0, 17'h0);
    chk(o_sig_rdata, 16'h00FF);
    for (int k = 0; k < 60; k++)
    begin
      tg = 2'(rnd());
      a = (tg == 2'h0) ? 17'(rnd()) : 17'(rnd() & (tg[1] ? 32'hF : 32'h1FF));
      pc = (tg == 2'h1 || (rnd() & 32'h1)) ? 17'h10000 | 17'(rnd() & 32'hFFF) : 17'(rnd() & 32'hFFFF);
      cpu(1'(rnd()), 1'(rnd()), tg, a, pc);
    end
    chk(o_fuse, 8'hFF);
    for (int k = 0; k < 20; k++)
      dec(corner[k % 10], k / 10);
    for (int k = 0; k < 30; k++)
      dec(24'(rnd() >> (rnd() % 12)), 1'(rnd()));
    i_fetch_data_space = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    chk(o_fetch_fault, 1'b1);
    i_fetch_data_space = 1'b0;
    i_fetch_waddr = 17'h11000;
    repeat (2) @(negedge i_clk_sys);
    chk(o_fetch_fault, 1'b1);
    i_fetch_waddr = 17'h10FFF;
    repeat (2) @(negedge i_clk_sys);
    chk(o_fetch_fault, 1'b0);
    mmnp_prog_model_i.send(4'h8, 2'h0, 17'h0ABCD, 16'h1234);
    chk({o_nvm_waddr, o_nvm_wdata}, {17'h0ABCD, 16'h1234});
    mmnp_prog_model_i.send(4'h8, 2'h3, 17'h0, 16'h00F0);
    chk(o_fuse, 8'hF0);
    lk = 8'hFF;
    for (int k = 0; k < 4; k++)
    begin
      v = (k == 2) ? 8'hFF : 8'(rnd()) | 8'hC0;
      {i_cpu_lock_data, i_cpu_lock_wr} = {v, 1'b1};
      @(negedge i_clk_sys);
      i_cpu_lock_wr = 1'b0;
      lk = lk & v;
      chk(o_lock, lk);
      @(negedge i_clk_sys);
    end
    mmnp_prog_model_i.send(4'h1, 2'h0, 17'h0, 16'h00BF);
    chk(o_lock, lk & 8'hBF);
    mmnp_prog_model_i.send(4'h2, 2'h0, 17'h0, 16'h0);
    chk(o_chip_erase_busy, 1'b1);
    chk(o_lock, lk & 8'hBF);
    for (w = 0; w < 80000 && o_chip_erase_busy; w++)
      @(negedge i_clk_sys);
    if (w == 80000)
      num_errors++;
    chk({ce_n[19:0], ce_last, o_lock}, {20'h11000, 17'h10FFF, 8'hFF});
    conclude;
  end
endmodule
`default_nettype wire
